//--- deiu_assertions.sv
// port checker for the event interrupt unit
`timescale 1ns/100ps
module deiu_assertions (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] busAddr,
    input wire logic busWr,
    input wire logic busRd,
    input wire logic loopLocked,
    input wire logic [1:0] refSelect,
    input wire logic [1:0] loopState,
    input wire logic [15:0] busRdata,
    input wire logic irqOut
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // flag read at the first cycle the event can show; no clear can slip in before it
    sequence flagRd; ##2 busRd && busAddr == 8'h66; endsequence
    property setBy(ev, b); ev ##0 flagRd |=> b; endproperty
    a_flag_res: assert property (busRd && busAddr == 8'h66 |=> !(busRdata & 16'hFFF1))
        else $error("flag reserved");
    a_rd_quiet: assert property (!busRd |=> busRdata == 16'h0) else $error("rdata");
    a_lock_set: assert property (setBy($changed(loopLocked), busRdata[3])) else $error("lk");
    a_ref_set: assert property (setBy($changed(refSelect), busRdata[2])) else $error("rf");
    a_hold_set: assert property (setBy($changed(loopState[0]), busRdata[1])) else $error("ho");
    a_irq_hold: assert property (irqOut && !busWr && !$past(busWr) |=> irqOut) else $error("i");
    a_irq_fall: assert property ($fell(irqOut) |-> $past(busWr, 2)) else $error("irq fell");
    a_stat_res: assert property (busRd && busAddr == 8'h6B |=> !busRdata[15:2]) else $error("s");
endmodule : deiu_assertions
bind dpll_event_interrupt_unit deiu_assertions chk_i (.core_clk, .rst_b, .busAddr, .busWr,
    .busRd, .loopLocked, .refSelect, .loopState, .busRdata, .irqOut);

//--- deiu_event_detect.sv
// change detector turning timing-loop status into one-cycle event pulses
`timescale 1ns/100ps
module deiu_event_detect (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire deiu_pkg::deiu_loop_t loopIn,
    output logic [2:0] evtPulse
);
    typedef struct packed {
        logic primed;
        deiu_pkg::deiu_loop_t prev;
        logic [2:0] evt;
    } deiu_det_state_t;

    deiu_det_state_t s_q;
    deiu_det_state_t s_d;
    logic holdNow;
    logic holdPrev;

    // holdover and phase-hold count as one family; entry or exit toggles it
    always_comb begin
        s_d = s_q;
        holdNow = (loopIn.loopState == deiu_pkg::MODE_HOLDOVER)
            || (loopIn.loopState == deiu_pkg::MODE_PHASE_HOLD);
        holdPrev = (s_q.prev.loopState == deiu_pkg::MODE_HOLDOVER)
            || (s_q.prev.loopState == deiu_pkg::MODE_PHASE_HOLD);
        s_d.prev = loopIn;
        s_d.primed = 1'b1;
        s_d.evt = 3'h0;
        // first cycle after reset only captures, so reset itself is no event
        if (s_q.primed) begin
            s_d.evt[deiu_pkg::BIT_LOCK - 1] = loopIn.locked != s_q.prev.locked;
            s_d.evt[deiu_pkg::BIT_REF - 1] = loopIn.refSel != s_q.prev.refSel;
            s_d.evt[deiu_pkg::BIT_HOLD - 1] = holdNow != holdPrev;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign evtPulse = s_q.evt;
endmodule : deiu_event_detect

//--- deiu_flag_bit.sv
// one sticky event flag with set-over-clear and mask gating
`timescale 1ns/100ps
module deiu_flag_bit (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic setEvt,
    input wire logic clrReq,
    input wire logic maskBit,
    output logic flagQ,
    output logic irqReq
);
    logic flag_q;
    logic flag_d;

    // set wins over a clear landing in the same cycle so no event is lost
    always_comb begin
        flag_d = flag_q;
        if (clrReq) begin
            flag_d = 1'b0;
        end
        if (setEvt) begin
            flag_d = 1'b1;
        end
    end

    // flag register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flag_q <= deiu_pkg::FLAGS_RESET[0];
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flagQ = flag_q;
    assign irqReq = flag_q & ~maskBit;
endmodule : deiu_flag_bit

//--- deiu_host.sv
// host model on the register bus
`timescale 1ns/100ps
module deiu_host (
    input wire logic core_clk,
    input wire logic [15:0] busRdata,
    output logic [7:0] busAddr,
    output logic [15:0] busWdata,
    output logic busWr,
    output logic busRd
);
    initial {busAddr, busWdata, busWr, busRd} = '0;
    // one-cycle write; reserved bits forced so stray values never reach the device
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge core_clk);
        busAddr <= a;
        busWdata <= (v & 16'h000E) | 16'h0001;
        busWr <= 1'b1;
        @(posedge core_clk);
        busWr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge core_clk);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge core_clk);
        busRd <= 1'b0;
        #1 v = busRdata;
    endtask : rd
endmodule : deiu_host

//--- deiu_pkg.sv
// package of constants and carrier types for the timing-loop event interrupt unit
package deiu_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] ADDR_FLAGS = 8'h66;
    localparam logic [7:0] ADDR_MASK = 8'h67;
    localparam logic [7:0] ADDR_CLEAR = 8'h68;
    localparam logic [7:0] ADDR_STATUS = 8'h6B;
    localparam int BIT_HOLD = 1;
    localparam int BIT_REF = 2;
    localparam int BIT_LOCK = 3;
    localparam logic [2:0] MASK_RESET = 3'h7;
    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam logic [15:0] CLEAR_READ = 16'h0001;
    localparam logic [1:0] MODE_PHASE_HOLD = 2'h0;
    localparam logic [1:0] MODE_NORMAL = 2'h1;
    localparam logic [1:0] MODE_HOLDOVER = 2'h2;
    localparam logic [1:0] MODE_FREERUN = 2'h3;

    typedef enum logic [1:0] {
        DEIU_IDLE = 2'h0,
        DEIU_READ = 2'h1
    } deiu_rd_state_t;

    // register bus request from the host
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } deiu_bus_req_t;

    // timing loop status as seen by the event detector
    typedef struct packed {
        logic locked;
        logic [1:0] refSel;
        logic [1:0] loopState;
    } deiu_loop_t;
endpackage : deiu_pkg

//--- dpll_event_interrupt_unit.sv
// timing-loop event interrupt unit: flags, mask, clear and status registers
//
// Overview of operation
// - event flag register reads zero on bits 15 to 4 and bit 0
// - bit 3 sets on any lock status change and holds until cleared
// - bit 2 sets when the selected reference changes
// - bit 1 sets on entering or leaving holdover/phase-hold
// - interrupt output active while any unmasked event flag is set
// - mask bits 3, 2, 1 suppress lock, reference, holdover contributions
// - writing one to clear bit 3..1 clears only that flag
// - loop state field: 00 phase-hold, 01 normal, 10 holdover, 11 freerun
`timescale 1ns/100ps
module dpll_event_interrupt_unit (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] busAddr,
    input wire logic [15:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    input wire logic loopLocked,
    input wire logic [1:0] refSelect,
    input wire logic [1:0] loopState,
    output logic [15:0] busRdata,
    output logic irqOut
);
    typedef struct packed {
        logic [2:0] mask;
        logic [15:0] rdata;
        logic irq;
        deiu_pkg::deiu_rd_state_t rdState;
    } deiu_top_state_t;

    deiu_top_state_t s_q;
    deiu_top_state_t s_d;
    deiu_pkg::deiu_bus_req_t req;
    deiu_pkg::deiu_loop_t loopNow;
    logic [2:0] evtPulse;
    logic [2:0] clrVec;
    logic [2:0] flags;
    logic [2:0] irqReq;
    logic [15:0] flagWord;
    logic [15:0] maskWord;
    logic [15:0] clearWord;
    logic [15:0] statusWord;
    logic [15:0] rdWord;
    logic [2:0] wrBits;
    logic hitFlags;
    logic hitMask;
    logic hitClear;
    logic hitStatus;
    logic wrMask;
    logic wrClear;
    logic irqAny;

    // gather bus and loop inputs into carriers
    assign req = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};
    assign loopNow = '{locked: loopLocked, refSel: refSelect, loopState: loopState};

    deiu_event_detect u_detect (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .loopIn(loopNow),
        .evtPulse(evtPulse)
    );

    // address decode, one hit line per mapped register
    assign hitFlags = req.addr == deiu_pkg::ADDR_FLAGS;
    assign hitMask = req.addr == deiu_pkg::ADDR_MASK;
    assign hitClear = req.addr == deiu_pkg::ADDR_CLEAR;
    assign hitStatus = req.addr == deiu_pkg::ADDR_STATUS;

    // flags and status are read-only, so writes there simply fall away
    assign wrMask = req.wr && hitMask;
    assign wrClear = req.wr && hitClear;

    // only the three event positions of a write carry meaning; reserved bits are ignored
    assign wrBits = req.wdata[deiu_pkg::BIT_LOCK:deiu_pkg::BIT_HOLD];

    // clear strobes, one per flag, live for the single write cycle
    assign clrVec = wrClear ? wrBits : 3'h0;

    // one sticky flag per event, index 0..2 maps to bits 1..3
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_flag
            deiu_flag_bit u_flag (
                .core_clk(core_clk),
                .rst_b(rst_b),
                .setEvt(evtPulse[gi]),
                .clrReq(clrVec[gi]),
                .maskBit(s_q.mask[gi]),
                .flagQ(flags[gi]),
                .irqReq(irqReq[gi])
            );
        end
    endgenerate

    // readback words built per bit; reserved positions tie off to their fixed pattern
    genvar bi;
    generate
        for (bi = 0; bi < 16; bi++) begin : g_word
            if (bi >= deiu_pkg::BIT_HOLD && bi <= deiu_pkg::BIT_LOCK) begin : g_evt
                assign flagWord[bi] = flags[bi - deiu_pkg::BIT_HOLD];
                assign maskWord[bi] = s_q.mask[bi - deiu_pkg::BIT_HOLD];
                assign clearWord[bi] = deiu_pkg::CLEAR_READ[bi];
            end else begin : g_rsv
                assign flagWord[bi] = 1'b0;
                assign maskWord[bi] = deiu_pkg::CLEAR_READ[bi]; // same fixed pattern as clear
                assign clearWord[bi] = deiu_pkg::CLEAR_READ[bi];
            end
        end
    endgenerate

    // loop state shown live, upper bits zero
    assign statusWord = {14'h0000, loopNow.loopState};

    // read select; anything off the map reads as zero
    always_comb begin
        rdWord = 16'h0000;
        if (hitFlags) begin
            rdWord = flagWord;
        end
        if (hitMask) begin
            rdWord = maskWord;
        end
        if (hitClear) begin
            rdWord = clearWord;
        end
        if (hitStatus) begin
            rdWord = statusWord;
        end
    end

    // any unmasked flag asks for the pin
    assign irqAny = |irqReq;

    // bus slave: mask write, read data registered one cycle after the strobe, interrupt level
    always_comb begin
        s_d = s_q;
        if (wrMask) begin
            s_d.mask = wrBits;
        end
        // read data stand for as many cycles as the strobe is held, then the word drops back to zero
        unique case (s_q.rdState)
            deiu_pkg::DEIU_IDLE: begin
                if (req.rd) begin
                    s_d.rdState = deiu_pkg::DEIU_READ;
                    s_d.rdata = rdWord;
                end
            end
            deiu_pkg::DEIU_READ: begin
                if (req.rd) begin
                    s_d.rdata = rdWord;
                end else begin
                    s_d.rdState = deiu_pkg::DEIU_IDLE;
                    s_d.rdata = 16'h0000;
                end
            end
            default: begin
                s_d.rdState = deiu_pkg::DEIU_IDLE;
                s_d.rdata = 16'h0000;
            end
        endcase
        // registered, so the pin lags the flag by one cycle
        s_d.irq = irqAny;
    end

    // state register; mask comes up all ones so nothing interrupts at reset
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s_q.mask <= deiu_pkg::MASK_RESET;
            s_q.rdata <= 16'h0000;
            s_q.irq <= 1'b0;
            s_q.rdState <= deiu_pkg::DEIU_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign busRdata = s_q.rdata;
    assign irqOut = s_q.irq;
endmodule : dpll_event_interrupt_unit

//--- dpll_event_interrupt_unit_test.sv
// self-checking bench for the event interrupt unit
`timescale 1ns/100ps
module dpll_event_interrupt_unit_test;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic loopLocked = 1'b0;
    logic [1:0] refSelect = 2'h0;
    logic [1:0] loopState = 2'h1;
    logic [7:0] busAddr;
    logic [15:0] busWdata, busRdata, d;
    logic busWr, busRd, irqOut;
    int n_fail = 0;
    int check_count = 0;
    // 20 MHz clock
    always #25 core_clk = ~core_clk;
    dpll_event_interrupt_unit uut (.core_clk, .rst_b, .busAddr, .busWdata, .busWr, .busRd,
        .loopLocked, .refSelect, .loopState, .busRdata, .irqOut);
    deiu_host host (.core_clk, .busRdata, .busAddr, .busWdata, .busWr, .busRd);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        host.rd(a, d);
        chk(d, e);
    endtask : rchk
    task automatic t_reset;
        rchk(8'h66, 16'h0000);
        rchk(8'h67, 16'h000F);
        rchk(8'h70, 16'h0000);
        rchk(8'h6B, 16'h0001);
        rchk(8'h68, 16'h0001);
        host.wr(8'h66, 16'h000E);
        rchk(8'h66, 16'h0000);
        chk({15'h0, irqOut}, 16'h0000);
    endtask : t_reset
    // all three events at once, then clear one flag alone
    task automatic t_events;
        host.wr(8'h67, 16'h0001);
        loopLocked <= 1'b1;
        refSelect <= 2'h1;
        loopState <= 2'h2;
        repeat (1) @(posedge core_clk);
        rchk(8'h66, 16'h000E);
        rchk(8'h6B, 16'h0002);
        chk({15'h0, irqOut}, 16'h0001);
        host.wr(8'h68, 16'h0004);
        rchk(8'h66, 16'h000A);
        host.wr(8'h68, 16'h000A);
        rchk(8'h66, 16'h0000);
        chk({15'h0, irqOut}, 16'h0000);
        // holdover to phase-hold stays in one family, so no event
        @(posedge core_clk);
        loopState <= 2'h0;
        repeat (1) @(posedge core_clk);
        rchk(8'h66, 16'h0000);
        // phase-hold to freerun leaves the family
        @(posedge core_clk);
        loopState <= 2'h3;
        repeat (1) @(posedge core_clk);
        rchk(8'h66, 16'h0002);
        host.wr(8'h68, 16'h0002);
    endtask : t_events
    // a masked flag still latches but stays off the output
    task automatic t_mask;
        host.wr(8'h67, 16'h0008);
        loopLocked <= 1'b0;
        repeat (1) @(posedge core_clk);
        rchk(8'h66, 16'h0008);
        chk({15'h0, irqOut}, 16'h0000);
        host.wr(8'h67, 16'h0000);
        repeat (3) @(posedge core_clk);
        chk({15'h0, irqOut}, 16'h0001);
    endtask : t_mask
    task automatic close_out;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    // main sequence after four reset cycles
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_events();
        t_mask();
        close_out();
    end
    // hang guard, far beyond the few dozen cycles needed
    initial begin
        #100000;
        n_fail++;
        close_out();
    end
endmodule : dpll_event_interrupt_unit_test
